/* File: logic/mesi_pkg.sv */
/*
 * Package for the modem event, status and interrupt block: register offsets,
 * bit positions, reset values and the carrier structs used at the ports.
 * Assumes a 16-bit register port with word addresses decoded by the host side.
 */
package mesi_pkg;

    // Register offsets (word addresses on the register port)
    localparam logic [7:0] MESI_OFS_SOFT_RESET = 8'h07;
    localparam logic [7:0] MESI_OFS_EVENT_FLAGS = 8'h20;
    localparam logic [7:0] MESI_OFS_IRQ_BLOCK = 8'h21;
    localparam logic [7:0] MESI_OFS_MODEM_CTRL = 8'h22;
    localparam logic [7:0] MESI_OFS_CONTROL = 8'h02;

    // Reset values and the software reset key
    localparam logic [15:0] MESI_RST_EVENT_FLAGS = 16'h0000;
    localparam logic [15:0] MESI_RST_IRQ_BLOCK = 16'h0024;
    localparam logic [15:0] MESI_RST_SOFT_RESET = 16'h0000;
    localparam logic [15:0] MESI_SOFT_RESET_KEY = 16'h0001;

    // Event status bit positions
    localparam int MESI_BIT_CTS = 0;
    localparam int MESI_BIT_CARRIER = 1;
    localparam int MESI_BIT_TX_EMPTY = 2;
    localparam int MESI_BIT_TX_FULL = 3;
    localparam int MESI_BIT_TX_LEVEL = 4;
    localparam int MESI_BIT_RX_EMPTY = 5;
    localparam int MESI_BIT_RX_FULL = 6;
    localparam int MESI_BIT_RX_LEVEL = 7;
    localparam int MESI_BIT_CRC = 8;
    localparam int MESI_BIT_WATCHDOG = 9;
    localparam int MESI_BIT_PARITY = 10;
    localparam int MESI_BIT_FRAME = 11;
    localparam int MESI_BIT_GAP = 12;
    localparam int MESI_BIT_JABBER_ENGAGED = 13;
    localparam int MESI_BIT_JAB_DONE = 14;
    localparam int MESI_BIT_RESET_SEEN = 15;

    // Control and modem-control bit positions
    localparam int MESI_BIT_IRQ_LEVEL = 2;
    localparam int MESI_BIT_INTERRUPT_POLARITY = 3;
    localparam int MESI_BIT_RTS = 0;
    localparam int MESI_BIT_LOOPBACK = 2;

    // Bits of the event register that are live, not sticky
    localparam logic [15:0] MESI_LIVE_MASK = 16'h60FF;
    // Bits the host may never clear by writing
    localparam logic [15:0] MESI_RO_MASK = 16'h0003;
    // Writable bits of the mask register (bit 15 reserved)
    localparam logic [15:0] MESI_BLOCK_WMASK = 16'h7FFF;
    // Writable bits of the control register: interrupt level and polarity
    localparam logic [15:0] MESI_CONTROL_WMASK = 16'h000C;
    // Writable bits of the modem control register: request-to-send and loopback
    localparam logic [15:0] MESI_MODEM_CTRL_WMASK = 16'h0005;

    // Raw event inputs from the modem core
    typedef struct packed {
        logic gap_err;
        logic frame_err;
        logic parity_err;
        logic watchdog_expired;
        logic crc_err;
    } mesi_events_t;

    // Live conditions from the modem core
    typedef struct packed {
        logic jabber_timeout_done;
        logic jabber_engaged;
        logic carrier_present;
        logic manchester_mode;
        logic rx_fifo_threshold_hit;
        logic rx_fifo_full_flag;
        logic rx_fifo_empty_flag;
        logic tx_fifo_threshold_hit;
        logic tx_fifo_full_flag;
        logic tx_fifo_empty_flag;
    } mesi_live_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } mesi_req_t;

endpackage : mesi_pkg

/* File: logic/mesi_top.sv */
/*
 * Event status, interrupt mask and software reset of the modem.
 * Assumes the serial port front end delivers decoded one-cycle read and
 * write strobes on clk, and that live inputs already come from clk logic.
 */
`timescale 1ns/10ps

module mesi_top (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire mesi_pkg::mesi_req_t     req,
    input  wire mesi_pkg::mesi_events_t  events,
    input  wire mesi_pkg::mesi_live_t    live,
    output logic                         rd_valid,
    output logic [15:0]                  rd_data,
    output logic                         irq_pin,
    output logic                         fifo_flush,
    output logic                         rts_out,
    output logic                         loopback_out
);
    import mesi_pkg::*;

    typedef struct packed {
        logic [15:0] flags;      // Sticky and live event flags
        logic [15:0] block;      // Interrupt mask
        logic [15:0] control;    // Interrupt mode and polarity
        logic [15:0] modem_ctrl; // Request-to-send and loopback
        logic [15:0] prev_irq;   // Last unmasked flags, for edge finding
        logic        irq_act;    // Interrupt asserted, before polarity
        logic        rd_valid;
        logic [15:0] rd_data;
        logic        irq_pin;
        logic        flush;
    } mesi_state_t;

    mesi_state_t state_q;
    mesi_state_t state_d;

    // Reset values shared by the power-on and software reset paths
    function automatic mesi_state_t mesi_defaults(input logic after_soft);
        mesi_state_t s;
        s = '0;
        s.flags = MESI_RST_EVENT_FLAGS;
        s.flags[MESI_BIT_RESET_SEEN] = after_soft;
        s.block = MESI_RST_IRQ_BLOCK;
        s.irq_pin = 1'b1;        // Inactive for the default active-low pin
        s.flush = after_soft;
        return s;
    endfunction : mesi_defaults

    // Write strobe aimed at one register offset; shared by every write decode
    function automatic logic mesi_wr_hit(input mesi_req_t r, input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : mesi_wr_hit

    logic [15:0] live_bits;
    logic [15:0] set_bits;
    logic [15:0] pending;
    logic        wr_flags;
    logic        soft_rst;

    // Live and event bits gathered into status layout
    always_comb begin
        live_bits = '0;
        set_bits = '0;
        live_bits[MESI_BIT_CTS] = state_q.modem_ctrl[MESI_BIT_RTS] & ~live.carrier_present
                                  & ~state_q.modem_ctrl[MESI_BIT_LOOPBACK];
        live_bits[MESI_BIT_CARRIER] = live.carrier_present & ~live.manchester_mode;
        live_bits[MESI_BIT_TX_EMPTY] = live.tx_fifo_empty_flag;
        live_bits[MESI_BIT_TX_FULL] = live.tx_fifo_full_flag;
        live_bits[MESI_BIT_TX_LEVEL] = live.tx_fifo_threshold_hit;
        live_bits[MESI_BIT_RX_EMPTY] = live.rx_fifo_empty_flag;
        live_bits[MESI_BIT_RX_FULL] = live.rx_fifo_full_flag;
        live_bits[MESI_BIT_RX_LEVEL] = live.rx_fifo_threshold_hit;
        live_bits[MESI_BIT_JABBER_ENGAGED] = live.jabber_engaged;
        live_bits[MESI_BIT_JAB_DONE] = live.jabber_timeout_done;
        set_bits[MESI_BIT_GAP] = events.gap_err & ~live.manchester_mode;
        set_bits[MESI_BIT_PARITY] = events.parity_err & ~live.manchester_mode;
        set_bits[MESI_BIT_FRAME] = events.frame_err;
        set_bits[MESI_BIT_WATCHDOG] = events.watchdog_expired;
        set_bits[MESI_BIT_CRC] = events.crc_err;
    end

    assign wr_flags = mesi_wr_hit(req, MESI_OFS_EVENT_FLAGS);
    // software reset key; any other value leaves the block alone
    assign soft_rst = mesi_wr_hit(req, MESI_OFS_SOFT_RESET)
                      && (req.wdata == MESI_SOFT_RESET_KEY);

    assign pending = state_q.flags & ~state_q.block & MESI_BLOCK_WMASK;

    // Next state: register writes, flag updates, interrupt and read data
    always_comb begin
        state_d = state_q;
        state_d.flush = 1'b0;
        state_d.rd_valid = 1'b0;
        if (soft_rst) begin
            state_d = mesi_defaults(1'b1);
        end else begin
            state_d.flags = (state_q.flags & ~MESI_LIVE_MASK)
                            & ~(wr_flags ? (req.wdata & ~MESI_RO_MASK) : 16'h0000);
            state_d.flags = (state_d.flags | set_bits) & ~MESI_LIVE_MASK;
            state_d.flags = state_d.flags | live_bits;
            // reset record keeps its sticky set
            if (state_q.flags[MESI_BIT_RESET_SEEN] && !(wr_flags
                    && req.wdata[MESI_BIT_RESET_SEEN])) begin
                state_d.flags[MESI_BIT_RESET_SEEN] = 1'b1;
            end
            if (mesi_wr_hit(req, MESI_OFS_IRQ_BLOCK)) begin
                state_d.block = req.wdata & MESI_BLOCK_WMASK;
            end
            if (mesi_wr_hit(req, MESI_OFS_CONTROL)) begin
                // Only level and polarity are kept, other bits read back zero
                state_d.control = req.wdata & MESI_CONTROL_WMASK;
            end
            if (mesi_wr_hit(req, MESI_OFS_MODEM_CTRL)) begin
                state_d.modem_ctrl = req.wdata & MESI_MODEM_CTRL_WMASK;
            end
            state_d.prev_irq = pending;
            if (state_q.control[MESI_BIT_IRQ_LEVEL]) begin
                state_d.irq_act = |pending;
            end else begin
                state_d.irq_act = |(pending & ~state_q.prev_irq);
            end
            if (req.rd) begin
                state_d.rd_valid = 1'b1;
                unique case (req.addr)
                    MESI_OFS_EVENT_FLAGS: state_d.rd_data = state_q.flags;
                    MESI_OFS_IRQ_BLOCK:   state_d.rd_data = state_q.block;
                    MESI_OFS_CONTROL:     state_d.rd_data = state_q.control;
                    MESI_OFS_MODEM_CTRL:  state_d.rd_data = state_q.modem_ctrl;
                    default:              state_d.rd_data = MESI_RST_SOFT_RESET;
                endcase
            end
        end
        state_d.irq_pin = state_d.control[MESI_BIT_INTERRUPT_POLARITY] ? state_d.irq_act
                                                             : ~state_d.irq_act;
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= mesi_defaults(1'b0);
        end else begin
            state_q <= state_d;
        end
    end

    assign rd_valid = state_q.rd_valid;
    assign rd_data = state_q.rd_data;
    assign irq_pin = state_q.irq_pin;
    assign fifo_flush = state_q.flush;
    assign rts_out = state_q.modem_ctrl[MESI_BIT_RTS];
    assign loopback_out = state_q.modem_ctrl[MESI_BIT_LOOPBACK];

endmodule : mesi_top

/* File: testbench/mesi_props.sv */
/* Port checker for mesi_top.
   Assumes it is bound onto mesi_top and samples on rising clk. */
`timescale 1ns/10ps
module mesi_props
    import mesi_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire mesi_pkg::mesi_req_t  req,
    input wire mesi_pkg::mesi_events_t events,
    input wire mesi_pkg::mesi_live_t live,
    input wire logic                 rd_valid,
    input wire logic [15:0]          rd_data,
    input wire logic                 irq_pin,
    input wire logic                 fifo_flush,
    input wire logic                 rts_out,
    input wire logic                 loopback_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Status read whose live sources held still for a cycle
    sequence s_live_rd;
        req.rd && req.addr == 8'h20 && $stable(live) && !$past(sys_rst) && !$past(req.wr);
    endsequence
    sequence s_key_wr;
        req.wr && req.addr == 8'h07 && req.wdata == 16'h0001;
    endsequence
    property p_flush; s_key_wr |=> fifo_flush; endproperty
    a_flush: assert property (p_flush) else $error("no flush after key");
    property p_noflush;
        !(req.wr && req.addr == 8'h07 && req.wdata == 16'h0001) |=> !fifo_flush;
    endproperty
    a_noflush: assert property (p_noflush) else $error("stray flush");
    property p_rstrd;
        req.rd && req.addr == 8'h07 |=> rd_valid && rd_data == 16'h0000;
    endproperty
    a_rstrd: assert property (p_rstrd) else $error("reset reg not zero");
    property p_m15; req.rd && req.addr == 8'h21 |=> !rd_data[15]; endproperty
    a_m15: assert property (p_m15) else $error("mask bit 15 set");
    property p_rts;
        req.wr && req.addr == 8'h22 |=> rts_out == $past(req.wdata[0]);
    endproperty
    a_rts: assert property (p_rts) else $error("rts mismatch");
    property p_loop;
        req.wr && req.addr == 8'h22 |=> loopback_out == $past(req.wdata[2]);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback mismatch");
    property p_cd;
        s_live_rd |=> rd_data[1] == $past(live.carrier_present & ~live.manchester_mode);
    endproperty
    a_cd: assert property (p_cd) else $error("carrier flag wrong");
    property p_fifo; s_live_rd |=> rd_data[7:2] == $past(live[5:0]); endproperty
    a_fifo: assert property (p_fifo) else $error("fifo flags wrong");
    property p_jab; s_live_rd |=> rd_data[14:13] == $past(live[9:8]); endproperty
    a_jab: assert property (p_jab) else $error("jabber flags wrong");
    property p_cts;
        s_live_rd |=> rd_data[0] == $past(rts_out & ~live.carrier_present & ~loopback_out);
    endproperty
    a_cts: assert property (p_cts) else $error("cts flag wrong");
    property p_pol; $fell(sys_rst) |-> irq_pin; endproperty
    a_pol: assert property (p_pol) else $error("irq active after reset");
endmodule : mesi_props
bind mesi_top mesi_props u_props (.clk(clk), .sys_rst(sys_rst), .req(req), .events(events),
    .live(live), .rd_valid(rd_valid), .rd_data(rd_data), .irq_pin(irq_pin),
    .fifo_flush(fifo_flush), .rts_out(rts_out), .loopback_out(loopback_out));

/* File: testbench/mesi_host.sv */
/* Host model on the register port of mesi_top.
   Assumes clk shared with the block; requests launch on falling edges. */
`timescale 1ns/10ps
module mesi_host (
    input  wire logic                clk,
    input  wire logic [15:0]         rd_data,
    output mesi_pkg::mesi_req_t      req
);
    import mesi_pkg::*;
    initial req = '0;
    // write strobe held for one rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req <= '0;
    endtask : wr
    // Read data is taken the cycle after the strobe, while rd_valid stands
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req <= '0;
        d = rd_data;
    endtask : rd
endmodule : mesi_host

/* File: testbench/testbench.sv */
/* Self-checking bench for mesi_top.
   Assumes mesi_props bind and mesi_host model compiled alongside. */
`timescale 1ns/10ps
module testbench;
    import mesi_pkg::*;
    logic clk, sys_rst, rd_valid, irq_pin, fifo_flush, rts_out, loopback_out;
    logic [15:0]  rd_data;
    mesi_req_t    req;
    mesi_events_t events;
    mesi_live_t   live;
    int bad_count, checked;
    mesi_host u_host (.clk(clk), .rd_data(rd_data), .req(req));
    mesi_top u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .events(events), .live(live),
        .rd_valid(rd_valid), .rd_data(rd_data), .irq_pin(irq_pin), .fifo_flush(fifo_flush),
        .rts_out(rts_out), .loopback_out(loopback_out));
    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdm(logic [7:0] a, logic [15:0] m, logic [15:0] e, string n);
        logic [15:0] v;
        u_host.rd(a, v);
        chk(n, e & m, v & m);
    endtask : rdm
    task automatic pulse(mesi_events_t e);
        @(negedge clk) events = e;
        @(negedge clk) events = '0;
        @(negedge clk);
    endtask : pulse
    task automatic t_defaults();
        rdm(8'h21, 16'hFFFF, 16'h0024, "mask");
        rdm(8'h20, 16'hFFFF, 16'h0024, "flags");
        rdm(8'h07, 16'hFFFF, 16'h0000, "rstreg");
        chk("irq", 16'h0001, 16'(irq_pin));
    endtask : t_defaults
    // Each event source in level mode: set, hold on zero write, clear on one
    task automatic t_events();
        logic [15:0] b;
        u_host.wr(8'h02, 16'h0004);
        for (int i = 0; i < 5; i++) begin
            b = 16'h0001 << (8 + i);
            pulse(mesi_events_t'(5'h01 << i));
            chk("irq", 16'h0000, 16'(irq_pin));
            rdm(8'h20, b, b, "event");
            u_host.wr(8'h20, 16'h0000);
            rdm(8'h20, b, b, "sticky");
            chk("irq", 16'h0000, 16'(irq_pin));
            u_host.wr(8'h20, b);
            rdm(8'h20, b, 16'h0000, "clear");
            chk("irq", 16'h0001, 16'(irq_pin));
        end
    endtask : t_events
    task automatic t_mask();
        // Keep both FIFO-empty bits blocked, the live empty flags are set
        u_host.wr(8'h21, 16'h0124);
        pulse(5'h01);
        chk("irq", 16'h0001, 16'(irq_pin));
        rdm(8'h20, 16'h0100, 16'h0100, "mskd");
        u_host.wr(8'h20, 16'h0100);
        u_host.wr(8'h21, 16'h0024);
        u_host.wr(8'h02, 16'h000C);
        chk("irq", 16'h0000, 16'(irq_pin));
        pulse(5'h01);
        chk("irq", 16'h0001, 16'(irq_pin));
        u_host.wr(8'h20, 16'h0100);
        // Edge mode, active high: one pulse per new event, flag left set
        u_host.wr(8'h02, 16'h0008);
        pulse(5'h01);
        chk("edge", 16'h0001, 16'(irq_pin));
        @(negedge clk);
        chk("edgeend", 16'h0000, 16'(irq_pin));
        rdm(8'h20, 16'h0100, 16'h0100, "edgeflag");
        u_host.wr(8'h20, 16'h0100);
    endtask : t_mask
    task automatic t_modem();
        u_host.wr(8'h22, 16'h0001);
        chk("rts", 16'h0001, 16'(rts_out));
        rdm(8'h20, 16'h0003, 16'h0001, "cts");
        @(negedge clk) live.carrier_present = 1'b1;
        rdm(8'h20, 16'h0003, 16'h0002, "cd");
        @(negedge clk) live.manchester_mode = 1'b1;
        rdm(8'h20, 16'h0003, 16'h0000, "fsk");
        @(negedge clk) live = '{rx_fifo_full_flag: 1, jabber_engaged: 1, tx_fifo_empty_flag: 1,
            rx_fifo_empty_flag: 1, default: 0};
        u_host.wr(8'h20, 16'hFFFF);
        rdm(8'h20, 16'h60FF, 16'h2065, "live");
        u_host.wr(8'h22, 16'h0005);
        chk("loop", 16'h0001, 16'(loopback_out));
        rdm(8'h20, 16'h0001, 16'h0000, "ctsl");
    endtask : t_modem
    task automatic t_soft();
        u_host.wr(8'h21, 16'hFFFF);
        rdm(8'h21, 16'hFFFF, 16'h7FFF, "mask15");
        u_host.wr(8'h07, 16'h0002);
        rdm(8'h21, 16'hFFFF, 16'h7FFF, "nokey");
        u_host.wr(8'h07, 16'h0001);
        chk("flush", 16'h0001, 16'(fifo_flush));
        chk("rts", 16'h0000, 16'(rts_out));
        chk("loopr", 16'h0000, 16'(loopback_out));
        rdm(8'h21, 16'hFFFF, 16'h0024, "mskrst");
        rdm(8'h20, 16'h8000, 16'h8000, "seen");
        u_host.wr(8'h20, 16'h8000);
        rdm(8'h20, 16'h8000, 16'h0000, "seenclr");
    endtask : t_soft
    task automatic summarize();
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Main sequence; the watchdog cuts a hang well past the expected span
    initial begin
        sys_rst = 1'b1;
        events = '0;
        live = '{tx_fifo_empty_flag: 1, rx_fifo_empty_flag: 1, default: 0};
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        t_defaults();
        t_events();
        t_mask();
        t_modem();
        t_soft();
        summarize();
    end
    initial begin
        #20us;
        bad_count++;
        summarize();
    end
endmodule : testbench
